/* File: include/chan_cfg_pkg.sv */
package chan_cfg_pkg;

  // Register map (word-indexed on the plain register port)
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_STATE = 4'h3;
  localparam logic [3:0] ADDR_LIMIT = 4'h4;

  // Configuration word field positions
  localparam int POS_TRIM = 31;
  localparam int POS_LOC_HI = 29;
  localparam int POS_LOC_LO = 24;
  localparam int POS_FLIP = 23;
  localparam int POS_SPAN_HI = 21;
  localparam int POS_SPAN_LO = 16;
  localparam int POS_FILL_IRQ = 15;
  localparam int POS_PROTO_HI = 14;
  localparam int POS_PROTO_LO = 12;
  localparam int POS_LSEL_HI = 11;
  localparam int POS_LSEL_LO = 10;
  localparam int POS_RAWFCS = 9;
  localparam int POS_MSK_RATE = 8;
  localparam int POS_MSK_UP = 7;
  localparam int POS_MSK_DOWN = 6;
  localparam int POS_MSK_DUP = 5;
  localparam int POS_MSK_LINE = 4;

  // Writable bits; reserved bits 30, 22 and 3:0 hold zero
  localparam logic [31:0] CONFIG_WMASK = 32'hbfbffff0;
  localparam logic [31:0] CONFIG_RESET = 32'h000001f0;
  localparam logic [31:0] MASK_RESET = 32'h00000000;

  // Event bit positions in status and mask registers
  localparam int EV_FILL_END = 0;
  localparam int EV_RATE = 1;
  localparam int EV_UP = 2;
  localparam int EV_DOWN = 3;
  localparam int EV_DUP = 4;
  localparam int EV_ABORT = 5;
  localparam int EV_IDLE = 6;
  localparam int EV_SHORT = 7;
  localparam int NUM_EV = 8;

  localparam logic [2:0] PROTO_TRANSPARENT = 3'h0;
  localparam logic [2:0] PROTO_SS7_FCS16 = 3'h1;
  localparam logic [2:0] PROTO_HDLC_FCS16 = 3'h2;
  localparam logic [2:0] PROTO_HDLC_FCS32 = 3'h3;

  localparam logic [1:0] LSEL_OFF = 2'h0;
  localparam logic [1:0] LSEL_ONE = 2'h1;
  localparam logic [1:0] LSEL_TWO = 2'h2;

  localparam logic [7:0] FILL_COUNT_RESET = 8'h00;

endpackage

/* File: include/cfg_view_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cfg_view_if;
  logic [31:0] word;
  logic trimEnable;
  logic polarityFlip;
  logic [5:0] startIndex;
  logic [7:0] spanDwords;
  logic fillIrqEnable;
  logic [2:0] protocol;
  logic protoValid;
  logic ss7Mode;
  logic fcsOff;
  logic [1:0] lengthLimitSelect;
  logic [4:0] irqMaskBits;
  modport src (output word);
  modport dec (input word, output trimEnable, polarityFlip, startIndex, spanDwords,
    fillIrqEnable, protocol, protoValid, ss7Mode, fcsOff, lengthLimitSelect, irqMaskBits);
  modport use_side (input trimEnable, polarityFlip, startIndex, spanDwords, fillIrqEnable,
    protocol, protoValid, ss7Mode, fcsOff, lengthLimitSelect, irqMaskBits);
endinterface
`default_nettype wire

/* File: hw/cfg_field_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module cfg_field_decode (
  cfg_view_if.dec view
);
  import chan_cfg_pkg::*;

  assign view.trimEnable = view.word[POS_TRIM];
  assign view.startIndex = view.word[POS_LOC_HI:POS_LOC_LO];
  assign view.polarityFlip = view.word[POS_FLIP];
  // Span is 2*(field+1) dwords, up to 128
  assign view.spanDwords = {1'b0, view.word[POS_SPAN_HI:POS_SPAN_LO], 1'b0} + 8'h02;
  assign view.fillIrqEnable = view.word[POS_FILL_IRQ];
  assign view.protocol = view.word[POS_PROTO_HI:POS_PROTO_LO];
  assign view.protoValid = (view.word[POS_PROTO_HI] == 1'b0);
  assign view.ss7Mode = (view.word[POS_PROTO_HI:POS_PROTO_LO] == PROTO_SS7_FCS16);
  assign view.fcsOff = view.word[POS_RAWFCS];
  assign view.lengthLimitSelect = view.word[POS_LSEL_HI:POS_LSEL_LO];
  assign view.irqMaskBits = view.word[POS_MSK_RATE:POS_MSK_LINE];
endmodule
`default_nettype wire

/* File: hw/hdlc_channel_config_decode.sv */
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module hdlc_channel_config_decode (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output logic irqOut,
  input wire logic isTransmit,
  input wire logic fillCountLoad,
  input wire logic [7:0] fillCountInit,
  input wire logic zeroInsertSeen,
  output logic [7:0] fill_count,
  output logic [5:0] fifo_start_index,
  output logic [7:0] fifo_span_size,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic [2:0] protocolSel,
  output logic protocolValid,
  output logic [11:0] activeLengthLimit,
  output logic lengthCheckOn,
  output logic rxStoreFcs,
  output logic txSendFcs,
  output logic shortCheckOn,
  input wire logic lastFillSent,
  input wire logic error_rate_threshold_event,
  input wire logic error_count_up_event,
  input wire logic error_count_down_event,
  input wire logic rxMessageDone,
  input wire logic rxMessageSame,
  output logic discardMessage,
  input wire logic abort_code_change_event,
  input wire logic idle_code_change_event,
  input wire logic short_frame_event
);
  import chan_cfg_pkg::*;

  logic [31:0] config_q;
  logic [NUM_EV-1:0] status_q;
  logic [NUM_EV-1:0] status_d;
  logic [NUM_EV-1:0] mask_q;
  logic [23:0] limits_q;
  logic [NUM_EV-1:0] evRaw;
  logic [NUM_EV-1:0] evGated;
  logic [31:0] rdMux;
  logic readStatus;

  cfg_view_if view ();

  assign view.word = config_q;

  cfg_field_decode u_decode (
    .view(view)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      config_q <= CONFIG_RESET;
    end else if (regWrite && regAddr == ADDR_CONFIG) begin
      // Reserved bits are forced low whatever the host writes
      config_q <= regWrData & CONFIG_WMASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mask_q <= MASK_RESET[NUM_EV-1:0];
    end else if (regWrite && regAddr == ADDR_MASK) begin
      mask_q <= regWrData[NUM_EV-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      limits_q <= 24'h000000;
    end else if (regWrite && regAddr == ADDR_LIMIT) begin
      limits_q <= regWrData[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Static decode outputs

  assign fifo_start_index = view.startIndex;
  assign fifo_span_size = view.spanDwords;
  assign protocolSel = view.protocol;
  assign protocolValid = view.protoValid;

  always_comb begin
    case (view.lengthLimitSelect)
      LSEL_ONE: begin
        activeLengthLimit = limits_q[11:0];
        lengthCheckOn = 1'b1;
      end
      LSEL_TWO: begin
        activeLengthLimit = limits_q[23:12];
        lengthCheckOn = 1'b1;
      end
      default: begin
        activeLengthLimit = 12'h000;
        lengthCheckOn = 1'b0;
      end
    endcase
  end

  // Transparent mode sends no FCS; the receive FCS store follows the raw FCS bit on receive and is low on transmit
  assign rxStoreFcs = view.fcsOff && !isTransmit;
  assign txSendFcs = !view.fcsOff && isTransmit && view.protocol != PROTO_TRANSPARENT;
  assign shortCheckOn = !view.fcsOff;

  ////////////////////////////////////////////////////////////////////////////
  // Data path and fill count

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dataOut <= 8'h00;
    end else if (view.polarityFlip) begin
      dataOut <= ~dataIn;
    end else begin
      dataOut <= dataIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fill_count <= FILL_COUNT_RESET;
    end else if (fillCountLoad) begin
      fill_count <= fillCountInit;
    end else if (zeroInsertSeen && view.trimEnable && fill_count != 8'h00) begin
      fill_count <= fill_count - 8'h01;
    end
    // Otherwise hold, also on zero insertion with trim off
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duplicate filter

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      discardMessage <= 1'b0;
    end else begin
      discardMessage <= rxMessageDone && rxMessageSame && view.ss7Mode && !isTransmit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  always_comb begin
    evRaw = '0;
    evRaw[EV_FILL_END] = isTransmit && lastFillSent && view.fillIrqEnable;
    evRaw[EV_RATE] = error_rate_threshold_event && !view.irqMaskBits[4];
    evRaw[EV_UP] = error_count_up_event && !view.irqMaskBits[3];
    evRaw[EV_DOWN] = error_count_down_event && !view.irqMaskBits[2];
    evRaw[EV_DUP] = rxMessageDone && rxMessageSame && !view.irqMaskBits[1];
    evRaw[EV_ABORT] = abort_code_change_event;
    evRaw[EV_IDLE] = idle_code_change_event;
    evRaw[EV_SHORT] = short_frame_event && !view.fcsOff;
  end

  // SS7 monitor events exist only on the receive side of an SS7 channel
  generate
    for (genvar i = 0; i < NUM_EV; i++) begin : g_gate
      if (i >= EV_RATE && i <= EV_DUP) begin : g_ss7
        assign evGated[i] = evRaw[i] && view.ss7Mode && !isTransmit;
      end else if (i >= EV_ABORT) begin : g_line
        assign evGated[i] = evRaw[i] && !view.irqMaskBits[0] && !isTransmit;
      end else begin : g_tx
        assign evGated[i] = evRaw[i];
      end
    end
  endgenerate

  assign readStatus = regRead && regAddr == ADDR_STATUS;

  // A new event in the clearing read cycle survives the clear
  always_comb begin
    status_d = readStatus ? evGated : (status_q | evGated);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  assign irqOut = |(status_q & ~mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    case (regAddr)
      ADDR_CONFIG: rdMux = config_q;
      ADDR_STATUS: rdMux = {24'h000000, status_q};
      ADDR_MASK: rdMux = {24'h000000, mask_q};
      ADDR_STATE: rdMux = {16'h0000, fill_count, fifo_span_size};
      ADDR_LIMIT: rdMux = {8'h00, limits_q};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regRdData <= 32'h00000000;
    end else if (regRead) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_TRIM_OFF_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!view.trimEnable && !fillCountLoad) |=> fill_count == $past(fill_count))
    else $error("fill count changed with trim off");

  AST_TRIM_ON_DEC: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (view.trimEnable && zeroInsertSeen && !fillCountLoad && fill_count != 8'h00)
    |=> fill_count == $past(fill_count) - 8'h01)
    else $error("fill count not reduced on zero insertion");

  AST_SPAN_SIZE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fifo_span_size == 8'((config_q[POS_SPAN_HI:POS_SPAN_LO] + 7'h01) * 2))
    else $error("fifo span size wrong");

  AST_DATA_PASS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!sys_rst && !config_q[POS_FLIP]) |=> dataOut == $past(dataIn))
    else $error("data altered with flip clear");

  AST_DATA_FLIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!sys_rst && config_q[POS_FLIP]) |=> dataOut == ~$past(dataIn))
    else $error("data not inverted with flip set");

  AST_FILL_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (isTransmit && lastFillSent && !config_q[POS_FILL_IRQ] && !status_q[EV_FILL_END])
    |=> !status_q[EV_FILL_END])
    else $error("fill-end event raised while disabled");

  AST_LSEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lengthCheckOn == (config_q[POS_LSEL_HI:POS_LSEL_LO] == LSEL_ONE
      || config_q[POS_LSEL_HI:POS_LSEL_LO] == LSEL_TWO))
    else $error("length check enable wrong");

  AST_FCS_MODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    config_q[POS_RAWFCS] |-> !txSendFcs && !shortCheckOn && (rxStoreFcs == !isTransmit))
    else $error("raw fcs mode outputs wrong");

  AST_UP_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (error_count_up_event && view.ss7Mode && !isTransmit && !config_q[POS_MSK_UP])
    |=> status_q[EV_UP])
    else $error("count-up event lost");

  AST_DUP_DISCARD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rxMessageDone && rxMessageSame && view.ss7Mode && !isTransmit) |=> discardMessage)
    else $error("duplicate not discarded");

  AST_START_INDEX: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fifo_start_index == config_q[POS_LOC_HI:POS_LOC_LO])
    else $error("fifo start index wrong");

  AST_PROTO_SEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    protocolSel == config_q[POS_PROTO_HI:POS_PROTO_LO]
      && protocolValid == (config_q[POS_PROTO_HI:POS_PROTO_LO] <= PROTO_HDLC_FCS32))
    else $error("protocol select wrong");

  AST_LIMIT_PICK: assert property (@(posedge ref_clk) disable iff (sys_rst)
    config_q[POS_LSEL_HI:POS_LSEL_LO] == LSEL_TWO |-> activeLengthLimit == limits_q[23:12])
    else $error("second length limit not selected");

  AST_FCS_NORMAL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !config_q[POS_RAWFCS] |-> !rxStoreFcs && shortCheckOn && txSendFcs == (isTransmit
      && config_q[POS_PROTO_HI:POS_PROTO_LO] != PROTO_TRANSPARENT))
    else $error("normal fcs mode outputs wrong");

  AST_SHORT_RAW: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (short_frame_event && config_q[POS_RAWFCS] && !status_q[EV_SHORT])
    |=> !status_q[EV_SHORT])
    else $error("short frame flagged in raw fcs mode");

  AST_RATE_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (error_rate_threshold_event && !isTransmit && !config_q[POS_MSK_RATE]
      && config_q[POS_PROTO_HI:POS_PROTO_LO] == PROTO_SS7_FCS16) |=> status_q[EV_RATE])
    else $error("threshold event lost");

  AST_DOWN_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (error_count_down_event && !isTransmit && !config_q[POS_MSK_DOWN]
      && config_q[POS_PROTO_HI:POS_PROTO_LO] == PROTO_SS7_FCS16) |=> status_q[EV_DOWN])
    else $error("count-down event lost");

  AST_DUP_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rxMessageDone && rxMessageSame && !isTransmit && !config_q[POS_MSK_DUP]
      && config_q[POS_PROTO_HI:POS_PROTO_LO] == PROTO_SS7_FCS16) |=> status_q[EV_DUP])
    else $error("duplicate event lost");

  AST_ABORT_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (abort_code_change_event && !isTransmit && !config_q[POS_MSK_LINE])
    |=> status_q[EV_ABORT])
    else $error("abort change event lost");

  AST_LINE_MASKED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (idle_code_change_event && config_q[POS_MSK_LINE] && !status_q[EV_IDLE])
    |=> !status_q[EV_IDLE])
    else $error("idle change recorded while masked");

  AST_FILL_IRQ_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (isTransmit && lastFillSent && config_q[POS_FILL_IRQ]) |=> status_q[EV_FILL_END])
    else $error("fill-end event lost");

  AST_SS7_TX_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (isTransmit && error_count_up_event && !status_q[EV_UP]) |=> !status_q[EV_UP])
    else $error("count-up event recorded on transmit");

  AST_TRIM_FLOOR: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (zeroInsertSeen && !fillCountLoad && fill_count == 8'h00) |=> fill_count == 8'h00)
    else $error("fill count wrapped below zero");

  AST_NO_DISCARD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (config_q[POS_PROTO_HI:POS_PROTO_LO] != PROTO_SS7_FCS16) |=> !discardMessage)
    else $error("discard outside signalling mode");

endmodule
`default_nettype wire

/* File: testbench/tb_hdlc_channel_config_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_hdlc_channel_config_decode;
  import chan_cfg_pkg::*;
  typedef struct {logic [31:0] cfg; logic tx; logic [41:0] exp;} row_s;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic isTransmit = 1'b0;
  logic [7:0] fillCountInit = 8'h00;
  logic [7:0] dataIn = 8'ha5;
  // Pulse inputs: 0 fill end, 1-3 error monitor, 4 same, 5-7 line, 8 zero, 9 load, 10 done
  logic [10:0] p = 11'h0;
  logic [31:0] regRdData;
  logic irqOut;
  logic [7:0] fill_count;
  logic [5:0] fifo_start_index;
  logic [7:0] fifo_span_size;
  logic [7:0] dataOut;
  logic [2:0] protocolSel;
  logic protocolValid;
  logic [11:0] activeLengthLimit;
  logic lengthCheckOn;
  logic rxStoreFcs;
  logic txSendFcs;
  logic shortCheckOn;
  logic discardMessage;
  int miscompares = 0;
  int n_checks = 0;
  row_s rows [5];

  hdlc_channel_config_decode hdlc_channel_config_decode_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irqOut(irqOut),
    .isTransmit(isTransmit), .fillCountLoad(p[9]), .fillCountInit(fillCountInit),
    .zeroInsertSeen(p[8]), .fill_count(fill_count), .fifo_start_index(fifo_start_index),
    .fifo_span_size(fifo_span_size), .dataIn(dataIn), .dataOut(dataOut),
    .protocolSel(protocolSel), .protocolValid(protocolValid),
    .activeLengthLimit(activeLengthLimit), .lengthCheckOn(lengthCheckOn),
    .rxStoreFcs(rxStoreFcs), .txSendFcs(txSendFcs), .shortCheckOn(shortCheckOn),
    .lastFillSent(p[0]), .error_rate_threshold_event(p[1]), .error_count_up_event(p[2]),
    .error_count_down_event(p[3]), .rxMessageDone(p[10]), .rxMessageSame(p[4]),
    .discardMessage(discardMessage), .abort_code_change_event(p[5]),
    .idle_code_change_event(p[6]), .short_frame_event(p[7])
  );

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chkv(input logic [41:0] g, input logic [41:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chkv({41'h0, g}, {41'h0, e});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    chkv({10'h0, regRdData}, {10'h0, e});
  endtask

  task automatic pulse(input logic [10:0] m);
    @(posedge ref_clk);
    p <= m;
    @(posedge ref_clk);
    p <= 11'h0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge ref_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    // Fields: index, span, data out, protocol, valid+length on, limit, rx fcs, tx fcs, short
    rows[0] = '{32'h3f3f0000, 1'b1, {6'h3f, 8'h80, 8'ha5, 3'h0, 2'b10, 12'h000, 3'b001}};
    rows[1] = '{32'h00001400, 1'b0, {6'h00, 8'h02, 8'ha5, 3'h1, 2'b11, 12'h123, 3'b001}};
    rows[2] = '{32'h05822800, 1'b1, {6'h05, 8'h06, 8'h5a, 3'h2, 2'b11, 12'habc, 3'b011}};
    rows[3] = '{32'h01013e00, 1'b0, {6'h01, 8'h04, 8'ha5, 3'h3, 2'b10, 12'h000, 3'b100}};
    rows[4] = '{32'h00b07200, 1'b1, {6'h00, 8'h62, 8'h5a, 3'h7, 2'b00, 12'h000, 3'b000}};
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wr(ADDR_LIMIT, 32'h00abc123);
    for (int r = 0; r < 5; r++) begin
      isTransmit <= rows[r].tx;
      wr(ADDR_CONFIG, rows[r].cfg);
      @(posedge ref_clk);
      #1;
      chkv({fifo_start_index, fifo_span_size, dataOut, protocolSel, protocolValid,
        lengthCheckOn, activeLengthLimit, rxStoreFcs, txSendFcs, shortCheckOn},
        rows[r].exp);
    end
    ////////////////////////////////////////////////////////////////////////////////
    isTransmit <= 1'b0;
    fillCountInit <= 8'h05;
    wr(ADDR_CONFIG, 32'h00000000);
    pulse(11'h200);
    pulse(11'h100);
    chkv({34'h0, fill_count}, 42'h5);
    wr(ADDR_CONFIG, 32'h80000000);
    pulse(11'h100);
    chkv({34'h0, fill_count}, 42'h4);
    rd(ADDR_STATE, 32'h00000402);
    // Each monitor and line event alone, so a crossed status bit shows up
    wr(ADDR_CONFIG, 32'h00001000);
    for (int i = 1; i < 8; i++) begin
      pulse(11'(1 << i) | ((i == 4) ? 11'h400 : 11'h0));
      chkb(irqOut, 1'b1);
      chkb(discardMessage, i == 4);
      rd(ADDR_STATUS, 32'(1 << i));
      chkb(irqOut, 1'b0);
    end
    wr(ADDR_CONFIG, 32'h000011f0);
    pulse(11'h4fe);
    chkb(discardMessage, 1'b1);
    chkb(irqOut, 1'b0);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_CONFIG, 32'h00002000);
    pulse(11'h4fe);
    chkb(discardMessage, 1'b0);
    rd(ADDR_STATUS, 32'he0);
    wr(ADDR_CONFIG, 32'h00002200);
    pulse(11'h080);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_CONFIG, 32'h00002010);
    pulse(11'h0e0);
    rd(ADDR_STATUS, 32'h0);
    isTransmit <= 1'b1;
    wr(ADDR_CONFIG, 32'h00008000);
    pulse(11'h001);
    chkb(irqOut, 1'b1);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_CONFIG, 32'h00000000);
    pulse(11'h001);
    rd(ADDR_STATUS, 32'h0);
    // Mask register hides the line but the sticky bit still records the event
    isTransmit <= 1'b0;
    wr(ADDR_CONFIG, 32'h00001000);
    wr(ADDR_MASK, 32'h00000004);
    rd(ADDR_MASK, 32'h00000004);
    pulse(11'h004);
    chkb(irqOut, 1'b0);
    rd(ADDR_STATUS, 32'h4);
    wr(ADDR_MASK, 32'h0);
    // Event in the clearing read cycle must survive the clear
    @(posedge ref_clk);
    regAddr <= ADDR_STATUS;
    regRead <= 1'b1;
    p <= 11'h004;
    @(posedge ref_clk);
    regRead <= 1'b0;
    p <= 11'h0;
    #1;
    chkv({10'h0, regRdData}, 42'h0);
    chkb(irqOut, 1'b1);
    rd(ADDR_STATUS, 32'h4);
    wr(ADDR_CONFIG, 32'hffffffff);
    rd(ADDR_CONFIG, CONFIG_WMASK);
    rd(4'hf, 32'h0);
    ////////////////////////////////////////////////////////////////////////////////
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chkb(irqOut, 1'b0);
    chkv({34'h0, fill_count}, {34'h0, FILL_COUNT_RESET});
    rd(ADDR_CONFIG, CONFIG_RESET);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_MASK, MASK_RESET);
    end_of_test();
  end
endmodule
`default_nettype wire
